//--- hub_cfg_regs.svh
// offsets, field positions, reset values and timing counts of the port configuration bank
`ifndef HUB_CFG_REGS_SVH
`define HUB_CFG_REGS_SVH

// ----------------------------------------------------------------------------
// register offsets on the configuration byte port
// ----------------------------------------------------------------------------
`define HUB_FIXED_MASK_OFS   8'h09
`define HUB_SP_OFF_MASK_OFS  8'h0a
`define HUB_BP_OFF_MASK_OFS  8'h0b
`define HUB_STATUS_OFS       8'h40

// ----------------------------------------------------------------------------
// field layout
// ----------------------------------------------------------------------------
`define HUB_NUM_PORTS        4
`define HUB_PORT_MSB         4
`define HUB_PORT_LSB         1
`define HUB_MASK_LIVE_BITS   8'h1e
`define HUB_LNUM_W           3
`define HUB_ST_VALID_POS     0
`define HUB_ST_REMAP_POS     1
`define HUB_ST_SELFPOW_POS   2
`define HUB_ST_COMPOUND_POS  3
`define HUB_ST_COUNT_LSB     4
`define HUB_ST_COUNT_MSB     6

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define HUB_MASK_RST         8'h00
`define HUB_RDATA_RST        8'h00

// ----------------------------------------------------------------------------
// fixed-port strap decode, one port vector per pin code
// ----------------------------------------------------------------------------
`define HUB_NR_CODE0         4'h0
`define HUB_NR_CODE1         4'h1
`define HUB_NR_CODE2         4'h3
`define HUB_NR_CODE3         4'h7

// ----------------------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------------------
`define HUB_STRAP_SETTLE     2'h2

`endif

//--- hub_cfg_pkg.sv
// types shared by the port configuration bank and its renumbering leaf
package hub_cfg_pkg;
  `include "hub_cfg_regs.svh"

  typedef logic [7:0]                                cfg_byte_t;
  typedef logic [`HUB_NUM_PORTS-1:0]                 port_vec_t;
  typedef logic [`HUB_LNUM_W-1:0]                    port_num_t;
  typedef logic [`HUB_NUM_PORTS*`HUB_LNUM_W-1:0]     lnum_vec_t;

  typedef enum logic [1:0] {
    ST_SETTLE,
    ST_CAPTURE,
    ST_HOLD
  } strap_state_e;
endpackage

//--- port_renumber.sv
// packs the active physical ports into consecutive logical numbers
`timescale 1ns/1ps
`include "hub_cfg_regs.svh"
module port_renumber (
  // physical port availability
  input  wire logic                   active_i,
  input  wire hub_cfg_pkg::port_vec_t ports_i,
  // logical numbering
  output hub_cfg_pkg::lnum_vec_t      lnum_o,
  output hub_cfg_pkg::port_num_t      count_o
);
  import hub_cfg_pkg::*;

  port_num_t run [0:`HUB_NUM_PORTS];

  assign run[0] = 3'h0;

  // lowest active physical port gets logical 1; disabled ports read 0
  for (genvar g = 0; g < `HUB_NUM_PORTS; g++) begin : g_port
    assign run[g+1] = run[g] + {2'h0, ports_i[g] & active_i};
    assign lnum_o[g*`HUB_LNUM_W +: `HUB_LNUM_W] = (ports_i[g] & active_i) ? run[g+1] : 3'h0;
  end

  assign count_o = run[`HUB_NUM_PORTS];
endmodule

//--- hub_port_fixed_and_disable_config.sv
// fixed-port and port-disable configuration of a four-port hub
`timescale 1ns/1ps
`include "hub_cfg_regs.svh"
module hub_port_fixed_and_disable_config (
  // clock and reset
  input  wire logic                   ref_clk_i,
  input  wire logic                   arst_n_i,
  // configuration byte port
  input  wire logic                   cfg_wr_en_i,
  input  wire logic                   cfg_rd_en_i,
  input  wire hub_cfg_pkg::cfg_byte_t cfg_addr_i,
  input  wire hub_cfg_pkg::cfg_byte_t cfg_wdata_i,
  output hub_cfg_pkg::cfg_byte_t      cfg_rdata_o,
  // mode selection from other configuration bytes
  input  wire logic                   use_strap_defaults_i,
  input  wire logic                   port_remap_select_i,
  input  wire logic                   compound_cfg_i,
  input  wire hub_cfg_pkg::port_vec_t remap_port_off_i,
  input  wire hub_cfg_pkg::lnum_vec_t remap_lnum_i,
  // pins
  input  wire logic                   self_powered_pin_i,
  input  wire logic [1:0]             fixed_port_strap_pins_i,
  input  wire hub_cfg_pkg::port_vec_t port_off_strap_plus_i,
  input  wire hub_cfg_pkg::port_vec_t port_off_strap_minus_i,
  // towards the hub core and descriptor logic
  output logic                        config_valid_o,
  output logic                        self_powered_o,
  output hub_cfg_pkg::port_vec_t      port_active_o,
  output hub_cfg_pkg::port_vec_t      port_fixed_o,
  output hub_cfg_pkg::port_num_t      port_count_o,
  output hub_cfg_pkg::lnum_vec_t      port_lnum_o,
  output hub_cfg_pkg::cfg_byte_t      removable_map_o,
  output logic                        compound_o
);
  import hub_cfg_pkg::*;

  // --------------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------------
  logic [10:0]  sync1_ff;
  logic [10:0]  sync2_ff;
  logic         pow_sync;
  logic [1:0]   nr_sync;
  port_vec_t    plus_sync;
  port_vec_t    minus_sync;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_ff <= 11'h000;
      sync2_ff <= 11'h000;
    end else begin
      sync1_ff <= {self_powered_pin_i, fixed_port_strap_pins_i,
                   port_off_strap_plus_i, port_off_strap_minus_i};
      sync2_ff <= sync1_ff;
    end
  end
  assign pow_sync   = sync2_ff[10];
  assign nr_sync    = sync2_ff[9:8];
  assign plus_sync  = sync2_ff[7:4];
  assign minus_sync = sync2_ff[3:0];

  // --------------------------------------------------------------------------
  // strap capture after reset release
  // --------------------------------------------------------------------------
  // straps are caught once, after the synchroniser has filled with pin levels
  strap_state_e state_ff;
  logic [1:0]   settle_ff;
  logic [1:0]   strap_nr_ff;
  port_vec_t    strap_off_ff;
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_ff  <= ST_SETTLE;
      settle_ff <= 2'h0;
    end else begin
      case (state_ff)
        ST_SETTLE: begin
          settle_ff <= settle_ff + 2'h1;
          if (settle_ff == `HUB_STRAP_SETTLE) begin
            state_ff <= ST_CAPTURE;
          end
        end
        ST_CAPTURE: state_ff <= ST_HOLD;
        ST_HOLD:    state_ff <= ST_HOLD;
        default:    state_ff <= ST_SETTLE;
      endcase
    end
  end
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      strap_nr_ff  <= 2'h0;
      strap_off_ff <= 4'h0;
    end else if (state_ff == ST_CAPTURE) begin
      strap_nr_ff  <= nr_sync;
      // a port is off only when both of its strap pins are high
      strap_off_ff <= plus_sync & minus_sync;
    end
  end

  // --------------------------------------------------------------------------
  // mask registers
  // --------------------------------------------------------------------------
  cfg_byte_t fixed_mask_ff;
  cfg_byte_t selfpow_port_off_mask_ff;
  cfg_byte_t buspow_port_off_mask_ff;

  // unused bits are never stored, so they cannot leak into port logic
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fixed_mask_ff            <= `HUB_MASK_RST;
      selfpow_port_off_mask_ff <= `HUB_MASK_RST;
      buspow_port_off_mask_ff  <= `HUB_MASK_RST;
    end else if (cfg_wr_en_i) begin
      case (cfg_addr_i)
        `HUB_FIXED_MASK_OFS:  fixed_mask_ff            <= cfg_wdata_i & `HUB_MASK_LIVE_BITS;
        `HUB_SP_OFF_MASK_OFS: selfpow_port_off_mask_ff <= cfg_wdata_i & `HUB_MASK_LIVE_BITS;
        `HUB_BP_OFF_MASK_OFS: buspow_port_off_mask_ff  <= cfg_wdata_i & `HUB_MASK_LIVE_BITS;
        default: begin
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // source selection
  // --------------------------------------------------------------------------
  logic      remap_on;
  logic      remap_on_ff;
  port_vec_t strap_fixed;
  port_vec_t fixed_sel;
  port_vec_t off_sel;
  port_vec_t active;

  // remap comes from the loaded configuration, so strap mode overrides it
  assign remap_on = port_remap_select_i & ~use_strap_defaults_i;

  always_comb begin
    case (strap_nr_ff)
      2'h0:    strap_fixed = `HUB_NR_CODE0;
      2'h1:    strap_fixed = `HUB_NR_CODE1;
      2'h2:    strap_fixed = `HUB_NR_CODE2;
      default: strap_fixed = `HUB_NR_CODE3;
    endcase
  end

  assign fixed_sel = use_strap_defaults_i ? strap_fixed :
                     fixed_mask_ff[`HUB_PORT_MSB:`HUB_PORT_LSB];
  always_comb begin
    if (remap_on) begin
      off_sel = remap_port_off_i;
    end else if (use_strap_defaults_i) begin
      off_sel = strap_off_ff;
    end else if (pow_sync) begin
      off_sel = selfpow_port_off_mask_ff[`HUB_PORT_MSB:`HUB_PORT_LSB];
    end else begin
      off_sel = buspow_port_off_mask_ff[`HUB_PORT_MSB:`HUB_PORT_LSB];
    end
  end

  // any pattern of set bits is legal; each bit only removes its own port
  assign active = ~off_sel;

  // --------------------------------------------------------------------------
  // numbering
  // --------------------------------------------------------------------------
  lnum_vec_t std_lnum;
  lnum_vec_t remap_lnum;
  port_num_t std_count;
  lnum_vec_t lnum_sel;

  port_renumber u_renumber (
    .active_i (1'b1),
    .ports_i  (active),
    .lnum_o   (std_lnum),
    .count_o  (std_count)
  );

  for (genvar g = 0; g < `HUB_NUM_PORTS; g++) begin : g_remap
    assign remap_lnum[g*`HUB_LNUM_W +: `HUB_LNUM_W] =
      active[g] ? remap_lnum_i[g*`HUB_LNUM_W +: `HUB_LNUM_W] : 3'h0;
  end
  assign lnum_sel = remap_on ? remap_lnum : std_lnum;

  // --------------------------------------------------------------------------
  // host-facing report
  // --------------------------------------------------------------------------
  // bit n of the map is logical port n, bit 0 unused as in hub descriptors
  cfg_byte_t rem_map;

  always_comb begin
    rem_map = 8'h00;
    for (int i = 0; i < `HUB_NUM_PORTS; i++) begin
      if (active[i] && fixed_sel[i]) begin
        rem_map[lnum_sel[i*`HUB_LNUM_W +: `HUB_LNUM_W]] = 1'b1;
      end
    end
    rem_map[0] = 1'b0;
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      port_active_o   <= 4'h0;
      port_fixed_o    <= 4'h0;
      port_count_o    <= 3'h0;
      port_lnum_o     <= 12'h000;
      removable_map_o <= 8'h00;
    end else begin
      // the hub core enables and enumerates only ports flagged here
      port_active_o   <= active;
      port_fixed_o    <= fixed_sel & active;
      port_count_o    <= std_count;
      port_lnum_o     <= lnum_sel;
      removable_map_o <= rem_map;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      compound_o     <= 1'b0;
      self_powered_o <= 1'b0;
      config_valid_o <= 1'b0;
      remap_on_ff    <= 1'b0;
    end else begin
      compound_o     <= use_strap_defaults_i ? (|strap_fixed) : compound_cfg_i;
      self_powered_o <= pow_sync;
      config_valid_o <= (state_ff == ST_HOLD);
      remap_on_ff    <= remap_on;
    end
  end

  // --------------------------------------------------------------------------
  // readback
  // --------------------------------------------------------------------------
  cfg_byte_t status;

  always_comb begin
    status = 8'h00;
    status[`HUB_ST_VALID_POS]    = config_valid_o;
    status[`HUB_ST_REMAP_POS]    = remap_on;
    status[`HUB_ST_SELFPOW_POS]  = self_powered_o;
    status[`HUB_ST_COMPOUND_POS] = compound_o;
    status[`HUB_ST_COUNT_MSB:`HUB_ST_COUNT_LSB] = port_count_o;
  end

  // data stands until the next read; unmapped offsets answer zero
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg_rdata_o <= `HUB_RDATA_RST;
    end else if (cfg_rd_en_i) begin
      case (cfg_addr_i)
        `HUB_FIXED_MASK_OFS:  cfg_rdata_o <= fixed_mask_ff;
        `HUB_SP_OFF_MASK_OFS: cfg_rdata_o <= selfpow_port_off_mask_ff;
        `HUB_BP_OFF_MASK_OFS: cfg_rdata_o <= buspow_port_off_mask_ff;
        `HUB_STATUS_OFS:      cfg_rdata_o <= status;
        default:              cfg_rdata_o <= 8'h00;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  logic lnum_ok;
  always_comb begin
    lnum_ok = 1'b1;
    for (int i = 0; i < `HUB_NUM_PORTS; i++) begin
      if (!port_active_o[i] && port_lnum_o[i*3 +: 3] != 3'h0) begin
        lnum_ok = 1'b0;
      end
      if (port_active_o[i] && !remap_on_ff &&
          port_lnum_o[i*3 +: 3] != 3'($countones(port_active_o & 4'((5'h2 << i) - 5'h1)))) begin
        lnum_ok = 1'b0;
      end
    end
  end
  sequence s_mask_mode;
    !use_strap_defaults_i && !port_remap_select_i;
  endsequence
  sequence s_pow_change;
    $changed(pow_sync) ##0 s_mask_mode;
  endsequence
  sequence s_mask_read;
    cfg_rd_en_i && cfg_addr_i inside {[`HUB_FIXED_MASK_OFS:`HUB_BP_OFF_MASK_OFS]};
  endsequence
  chk_fixed_from_mask: assert property (!use_strap_defaults_i |=>
    port_fixed_o == ($past(fixed_mask_ff[4:1]) & port_active_o))
    else $error("fixed ports differ from fixed mask");
  chk_fixed_from_strap: assert property (use_strap_defaults_i && state_ff == ST_HOLD |=>
    port_fixed_o == ($past(strap_fixed) & port_active_o))
    else $error("fixed ports differ from strap pins");
  chk_reserved_zero: assert property (s_mask_read |=>
    cfg_rdata_o[0] == 1'b0 && cfg_rdata_o[7:5] == 3'h0)
    else $error("reserved mask bits read nonzero");
  chk_selfpow_mask: assert property (s_mask_mode ##0 pow_sync |=>
    port_active_o == ~$past(selfpow_port_off_mask_ff[4:1]))
    else $error("self-powered mask not applied");
  chk_buspow_mask: assert property (s_mask_mode ##0 !pow_sync |=>
    port_active_o == ~$past(buspow_port_off_mask_ff[4:1]))
    else $error("bus-powered mask not applied");
  chk_port_count: assert property (port_count_o == 3'($countones(port_active_o)))
    else $error("port count differs from enabled ports");
  chk_lnum_order: assert property (##1 lnum_ok)
    else $error("logical numbering not consecutive");
  chk_remap_override: assert property (remap_on |=> port_active_o == ~$past(remap_port_off_i))
    else $error("remap mode did not override masks");
  chk_strap_disable: assert property (use_strap_defaults_i && state_ff == ST_HOLD |=>
    port_active_o == ~$past(strap_off_ff))
    else $error("strap disables not applied");
  chk_compound_strap: assert property (use_strap_defaults_i && |strap_fixed |=> compound_o)
    else $error("compound not reported for strapped fixed port");
  chk_power_switch: assert property (s_pow_change |=> self_powered_o == $past(pow_sync) ##1
    self_powered_o == $past(pow_sync))
    else $error("power source change not followed");
  chk_removable_map: assert property (removable_map_o[0] == 1'b0 &&
    $countones(removable_map_o) == $countones(port_fixed_o))
    else $error("removable map disagrees with fixed ports");
  chk_strap_valid: assert property (!config_valid_o |-> ##[1:6] config_valid_o)
    else $error("configuration never became valid");
endmodule

//--- cfg_source.sv
// configuration source model that loads and reads back the port masks
`timescale 1ns/1ps
module cfg_source (
  // clock
  input  wire logic                   ref_clk_i,
  // configuration byte port
  output logic                        cfg_wr_en_o,
  output logic                        cfg_rd_en_o,
  output hub_cfg_pkg::cfg_byte_t      cfg_addr_o,
  output hub_cfg_pkg::cfg_byte_t      cfg_wdata_o,
  input  wire hub_cfg_pkg::cfg_byte_t cfg_rdata_i
);
  import hub_cfg_pkg::*;
  // attached devices answer for their own descriptors, nothing here does
  initial begin
    cfg_wr_en_o = 1'b0;
    cfg_rd_en_o = 1'b0;
    cfg_addr_o  = 8'hff;
    cfg_wdata_o = 8'hff;
  end
  // released lines show the inverse of the last value, so stale data never matches
  task automatic write(input cfg_byte_t addr, input cfg_byte_t data);
    @(negedge ref_clk_i);
    cfg_addr_o  = addr;
    cfg_wdata_o = data;
    cfg_wr_en_o = 1'b1;
    @(negedge ref_clk_i);
    cfg_wr_en_o = 1'b0;
    cfg_addr_o  = ~addr;
    cfg_wdata_o = ~data;
  endtask
  // read data is registered and holds, so sample one and a half cycles after the taking edge
  task automatic read(input cfg_byte_t addr, output cfg_byte_t data);
    @(negedge ref_clk_i);
    cfg_addr_o  = addr;
    cfg_rd_en_o = 1'b1;
    @(negedge ref_clk_i);
    cfg_rd_en_o = 1'b0;
    cfg_addr_o  = ~addr;
    @(negedge ref_clk_i);
    data = cfg_rdata_i;
  endtask
endmodule

//--- testbench.sv
// self-checking bench for the fixed-port and port-disable configuration bank
`timescale 1ns/1ps
`include "hub_cfg_regs.svh"
module testbench;
  import hub_cfg_pkg::*;
  typedef struct {
    cfg_byte_t sp;
    cfg_byte_t bp;
    cfg_byte_t fx;
    logic      pw;
    port_vec_t act;
    port_num_t cnt;
    lnum_vec_t lnum;
    port_vec_t fix;
    cfg_byte_t rmap;
  } row_s;
  // ----------------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------------
  logic      ref_clk_i = 1'b0;
  logic      arst_n_i;
  logic      cfg_wr_en, cfg_rd_en;
  cfg_byte_t cfg_addr, cfg_wdata, cfg_rdata, rd;
  logic      use_strap, remap_sel, compound_cfg, self_pow_pin;
  port_vec_t remap_off, strap_plus, strap_minus;
  lnum_vec_t remap_lnum;
  logic [1:0] fixed_pins;
  logic      config_valid, self_powered, compound;
  port_vec_t port_active, port_fixed;
  port_num_t port_count;
  lnum_vec_t port_lnum;
  cfg_byte_t removable_map;
  int        errors     = 0;
  int        num_checks = 0;
  row_s      rows [7];
  always #2.5 ref_clk_i = ~ref_clk_i;
  // ----------------------------------------------------------------------------
  // design and configuration source
  // ----------------------------------------------------------------------------
  cfg_source src_u (.ref_clk_i(ref_clk_i), .cfg_wr_en_o(cfg_wr_en), .cfg_rd_en_o(cfg_rd_en),
    .cfg_addr_o(cfg_addr), .cfg_wdata_o(cfg_wdata), .cfg_rdata_i(cfg_rdata));
  hub_port_fixed_and_disable_config dut_u (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
    .cfg_wr_en_i(cfg_wr_en), .cfg_rd_en_i(cfg_rd_en), .cfg_addr_i(cfg_addr),
    .cfg_wdata_i(cfg_wdata), .cfg_rdata_o(cfg_rdata), .use_strap_defaults_i(use_strap),
    .port_remap_select_i(remap_sel), .compound_cfg_i(compound_cfg),
    .remap_port_off_i(remap_off), .remap_lnum_i(remap_lnum),
    .self_powered_pin_i(self_pow_pin), .fixed_port_strap_pins_i(fixed_pins),
    .port_off_strap_plus_i(strap_plus), .port_off_strap_minus_i(strap_minus),
    .config_valid_o(config_valid), .self_powered_o(self_powered),
    .port_active_o(port_active), .port_fixed_o(port_fixed), .port_count_o(port_count),
    .port_lnum_o(port_lnum), .removable_map_o(removable_map), .compound_o(compound));
  // ----------------------------------------------------------------------------
  // compare and closing tasks
  // ----------------------------------------------------------------------------
  task automatic check_byte(input cfg_byte_t got, input cfg_byte_t exp, input string what);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic check_lnum(input lnum_vec_t got, input lnum_vec_t exp, input string what);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp, input string what);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask
  task automatic complete_run();
    if (errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------------------
  // watchdog: the whole sequence needs well under a thousand cycles
  // ----------------------------------------------------------------------------
  initial begin
    #20000;
    errors++;
    complete_run();
  end
  // ----------------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------------
  initial begin
    rows = '{'{8'h00, 8'h00, 8'h00, 1'b1, 4'hf, 3'd4, 12'h8d1, 4'h0, 8'h00},
             '{8'h02, 8'h00, 8'h04, 1'b1, 4'he, 3'd3, 12'h688, 4'h2, 8'h02},
             '{8'he1, 8'h1e, 8'h00, 1'b1, 4'hf, 3'd4, 12'h8d1, 4'h0, 8'h00},
             '{8'he1, 8'h1e, 8'h00, 1'b0, 4'h0, 3'd0, 12'h000, 4'h0, 8'h00},
             '{8'h00, 8'h0a, 8'h1e, 1'b0, 4'ha, 3'd2, 12'h408, 4'ha, 8'h06},
             '{8'h14, 8'hff, 8'h10, 1'b1, 4'h5, 3'd2, 12'h081, 4'h0, 8'h00},
             '{8'h1e, 8'h00, 8'h02, 1'b1, 4'h0, 3'd0, 12'h000, 4'h0, 8'h00}};
    arst_n_i     = 1'b0;
    use_strap    = 1'b0;
    remap_sel    = 1'b0;
    compound_cfg = 1'b0;
    self_pow_pin = 1'b1;
    remap_off    = 4'h0;
    remap_lnum   = 12'h000;
    fixed_pins   = 2'b00;
    strap_plus   = 4'h0;
    strap_minus  = 4'h0;
    repeat (5) @(negedge ref_clk_i);
    arst_n_i = 1'b1;
    repeat (8) @(negedge ref_clk_i);
    check_bit(config_valid, 1'b1, "config valid");
    foreach (rows[i]) begin
      src_u.write(`HUB_SP_OFF_MASK_OFS, rows[i].sp);
      src_u.write(`HUB_BP_OFF_MASK_OFS, rows[i].bp);
      src_u.write(`HUB_FIXED_MASK_OFS, rows[i].fx);
      self_pow_pin = rows[i].pw;
      repeat (5) @(negedge ref_clk_i);
      check_byte({4'h0, port_active}, {4'h0, rows[i].act}, "active");
      check_byte({5'h0, port_count}, {5'h0, rows[i].cnt}, "count");
      check_lnum(port_lnum, rows[i].lnum, "numbering");
      check_byte({4'h0, port_fixed}, {4'h0, rows[i].fix}, "fixed");
      check_byte(removable_map, rows[i].rmap, "removable map");
      check_bit(self_powered, rows[i].pw, "power source");
      src_u.read(`HUB_SP_OFF_MASK_OFS, rd);
      check_byte(rd, rows[i].sp & `HUB_MASK_LIVE_BITS, "sp readback");
      src_u.read(`HUB_BP_OFF_MASK_OFS, rd);
      check_byte(rd, rows[i].bp & `HUB_MASK_LIVE_BITS, "bp readback");
      src_u.read(`HUB_FIXED_MASK_OFS, rd);
      check_byte(rd, rows[i].fx & `HUB_MASK_LIVE_BITS, "fixed readback");
      src_u.read(`HUB_STATUS_OFS, rd);
      check_byte(rd & 8'h7f, {1'b0, rows[i].cnt, 1'b0, rows[i].pw, 2'b01}, "status");
    end
    // unmapped offset reads as zero
    src_u.read(8'h0c, rd);
    check_byte(rd, 8'h00, "unmapped read");
    // remap mode overrides a mask that has every port off
    remap_off    = 4'h3;
    // disabled ports carry stale numbers that must read as zero
    remap_lnum   = 12'h289;
    remap_sel    = 1'b1;
    compound_cfg = 1'b1;
    repeat (5) @(negedge ref_clk_i);
    check_byte({4'h0, port_active}, 8'h0c, "remap active");
    check_lnum(port_lnum, 12'h280, "remap numbering");
    src_u.read(`HUB_STATUS_OFS, rd);
    check_byte(rd & 8'h7a, 8'h2a, "remap status");
    remap_sel    = 1'b0;
    compound_cfg = 1'b0;
    repeat (5) @(negedge ref_clk_i);
    check_byte({4'h0, port_active}, 8'h00, "remap off");
    // reset in mid-run, then strap defaults with a non-contiguous disable set
    arst_n_i    = 1'b0;
    use_strap   = 1'b1;
    remap_sel   = 1'b1;
    fixed_pins  = 2'b10;
    strap_plus  = 4'h5;
    strap_minus = 4'h7;
    #1;
    check_byte({4'h0, port_active}, 8'h00, "active in reset");
    check_byte(cfg_rdata, 8'h00, "rdata in reset");
    repeat (5) @(negedge ref_clk_i);
    arst_n_i = 1'b1;
    repeat (10) @(negedge ref_clk_i);
    // straps are captured once, later pin motion must not matter
    strap_plus  = 4'h0;
    fixed_pins  = 2'b00;
    repeat (5) @(negedge ref_clk_i);
    check_bit(config_valid, 1'b1, "strap valid");
    check_byte({4'h0, port_active}, 8'h0a, "strap active");
    check_byte({4'h0, port_fixed}, 8'h02, "strap fixed");
    check_lnum(port_lnum, 12'h408, "strap numbering");
    check_byte(removable_map, 8'h02, "strap removable");
    check_bit(compound, 1'b1, "strap compound");
    src_u.read(`HUB_SP_OFF_MASK_OFS, rd);
    check_byte(rd, `HUB_MASK_RST, "mask after reset");
    complete_run();
  end
endmodule
